/* dv/pidfc_partner.sv */
`timescale 1ns/1ns
`default_nettype none
// Analog channels: jump to target, or slew one step a clock when slow
module pidfc_partner
  import pidfc_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             slow,
  input  wire logic [SIG_W-1:0] tgt [5],
  output logic      [SIG_W-1:0] ch  [5]
);
  // Slewing stands in for a filtered sensor, so loops see gradual change
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 5; i++) begin
      if (!rstn) ch[i] <= '0;
      else if (!slow || ch[i] == tgt[i]) ch[i] <= tgt[i];
      else if (ch[i] < tgt[i]) ch[i] <= ch[i] + 1'b1;
      else ch[i] <= ch[i] - 1'b1;
    end
  end
endmodule // pidfc_partner
`default_nettype wire

/* dv/pidfc_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module pidfc_tb_top
  import pidfc_pkg::*;
;
  localparam int TK = 20;
  typedef struct packed {
    logic [31:0] e;
    logic [31:0] m;
    logic        nz;
  } pidfc_note_t;
  logic             clk_sys = 0, rstn = 0, slow = 0;
  logic             avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [7:0]       avs_address = '0;
  logic [31:0]      avs_writedata = '0, avs_readdata, rd_val;
  logic [3:0]       avs_byteenable = 4'hF;
  logic [15:0]      freq_ref;
  logic             pid_run, feedback_loss_indication, drive_stop;
  logic [9:0]       fb_display;
  logic [SIG_W-1:0] tgt [5] = '{default: '0};
  logic [SIG_W-1:0] ch [5];
  int               failures = 0, checked = 0, seed = 71;
  pidfc_note_t      notes [$];

  pidfc_top #(.TICK_CYC(TK), .FMAX_CHZ(FMAX_CHZ_DEF)) pidfc_top_inst (
    .clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .keypad_pot(ch[0]), .voltage_analog_input(ch[1]),
    .current_analog_input(ch[2]), .comm_target(ch[3]), .comm_freq(ch[4]),
    .freq_ref(freq_ref), .pid_run(pid_run),
    .feedback_loss_indication(feedback_loss_indication),
    .drive_stop(drive_stop), .fb_display(fb_display));
  pidfc_partner pidfc_partner_inst (.clk_sys(clk_sys), .rstn(rstn),
    .slow(slow), .tgt(tgt), .ch(ch));

  initial forever #25 clk_sys = ~clk_sys;
  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
  end

  // Read data taken at the edge that sees waitrequest low
  always @(posedge clk_sys) begin : mon
    pidfc_note_t nt;
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (notes.size() > 0) begin
        nt = notes.pop_front();
        if (nt.nz) `CHK("out nonzero", 1'b1, |(avs_readdata & nt.m))
        else `CHK($sformatf("reg %h", avs_address), nt.e, avs_readdata & nt.m)
      end
    end
  end

  // One Avalon access; held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic chk,
                     input logic [31:0] e, m, input logic nz);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    if (chk) notes.push_back('{e, m, nz});
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd_val = avs_readdata;
    if (n >= 50) `CHK("waitrequest", 1'b0, avs_waitrequest)
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b0, '0, '0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    bus(1'b0, a, '0, 1'b1, e, m, 1'b0);
  endtask
  task automatic rdnz(input logic [7:0] a, input logic [31:0] m);
    bus(1'b0, a, '0, 1'b1, '0, m, 1'b1);
  endtask
  // Bounded wait on a register condition; loop updates are tick paced
  task automatic poll(input logic [7:0] a, input logic [31:0] m, e,
                      input logic nz);
    int k;
    logic [31:0] got;
    for (k = 0; k < 400; k++) begin
      bus(1'b0, a, '0, 1'b0, '0, '0, 1'b0);
      got = nz ? 32'(|(rd_val & m)) : rd_val & m;
      if (got === (nz ? 32'h1 : e)) break;
    end
    if (k == 400) `CHK($sformatf("wait %h", a), nz ? 32'h1 : e, got)
  endtask
  function automatic logic [31:0] ctl(int sp, fb, op, lm, pol);
    return (32'(sp) << CTRL_SP_LSB) | (32'(fb) << CTRL_FB_LSB)
      | (32'(op) << CTRL_OP_LSB) | (32'(FSRC_PID) << CTRL_FSRC_LSB)
      | (32'(pol) << CTRL_OPOL_BIT) | (32'(lm) << CTRL_LMODE_LSB);
  endfunction
  task summarize;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge clk_sys);
    repeat (88000) @(posedge clk_sys);
    failures++;
    summarize();
  end

  initial begin
    @(posedge rstn);
    // Reset values, unmapped space, read-only output word
    rd(REG_CTRL, CFG_RST[0], '1);
    rd(REG_GAIN, CFG_RST[1], '1);
    rd(REG_DISP, CFG_RST[7], '1);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, '0, '1);
    wr(REG_OUT, 32'hFFFF_FFFF);
    rd(REG_OUT, '0, 32'h0000_FFFF);
    $display("test reset done");
    // Every setpoint code against a distinct feedback code, both senses
    wr(REG_KEY, 32'h0000_03E8);
    for (int i = 0; i < 5; i++) begin
      for (int j = 0; j < 5; j++) tgt[j] <= (j == i) ? 14'h1770 : 14'h0000;
      wr(REG_CTRL, ctl(i, i == 0 ? 3 : i - 1, 1, 0, 0));
      poll(REG_OUT, 32'h0000_FFFF, '0, 1'b1);
      rdnz(REG_OUT, 32'h0000_FFFF);
      `CHK("run pin", 1'b1, pid_run)
      rd(REG_STAT, 32'h0000_0010, 32'h0000_0010);
      wr(REG_CTRL, ctl(i, i == 0 ? 3 : i - 1, 3, 0, 0));
      poll(REG_OUT, 32'h0000_FFFF, '0, 1'b0);
      rd(REG_OUT, '0, 32'h0000_FFFF);
    end
    wr(REG_CTRL, ctl(1, 0, 0, 0, 0));
    poll(REG_STAT, 32'h0000_0010, '0, 1'b0);
    rd(REG_OUT, '0, 32'h0000_FFFF);
    `CHK("run pin", 1'b0, pid_run)
    // Another frequency source takes the drive away from the loop
    wr(REG_CTRL, ctl(4, 3, 1, 0, 0));
    poll(REG_OUT, 32'h0000_FFFF, '0, 1'b1);
    wr(REG_CTRL, ctl(4, 3, 1, 0, 0) & ~(32'hF << CTRL_FSRC_LSB));
    poll(REG_STAT, 32'h0000_0010, '0, 1'b0);
    rd(REG_OUT, '0, 32'h0000_FFFF);
    `CHK("run pin", 1'b0, pid_run)
    $display("test direction done");
    // Offset alone drives the output when deviation is zero
    for (int j = 0; j < 5; j++) tgt[j] <= 14'h0000;
    wr(REG_KEY, '0);
    wr(REG_LIM, 32'd50 << LIM_OFS_LSB);
    wr(REG_CTRL, ctl(4, 1, 1, 0, 0));
    poll(REG_OUT, 32'h0000_FFFF, '0, 1'b1);
    rdnz(REG_OUT, 32'h0000_FFFF);
    wr(REG_CTRL, ctl(4, 1, 1, 0, 1));
    poll(REG_OUT, 32'h0000_FFFF, '0, 1'b0);
    rd(REG_OUT, '0, 32'h0000_FFFF);
    $display("test offset done");
    // Loss: 10 % level, 0.1 s delay, setpoint well above feedback
    tgt[1] <= 14'h1F40;
    wr(REG_LIM, 32'd10 << LIM_LOSS_LSB);
    wr(REG_DLY, 32'd1 << DLY_LOSS_LSB);
    wr(REG_CTRL, ctl(1, 2, 1, 1, 0));
    repeat (4 * TK) @(posedge clk_sys);
    rd(REG_STAT, '0, 32'h0000_0001);
    poll(REG_STAT, 32'h0000_0001, 32'h0000_0001, 1'b0);
    rd(REG_STAT, 32'h0000_0001, 32'h0000_0003);
    `CHK("loss pin", 1'b1, feedback_loss_indication)
    // Clear while the loss persists: the new loss wins
    wr(REG_STAT, 32'h0000_0001);
    rd(REG_STAT, 32'h0000_0001, 32'h0000_0001);
    wr(REG_CTRL, ctl(1, 2, 1, 2, 0));
    poll(REG_STAT, 32'h0000_0002, 32'h0000_0002, 1'b0);
    rd(REG_STAT, 32'h0000_0003, 32'h0000_0003);
    `CHK("stop pin", 1'b1, drive_stop)
    `CHK("run pin", 1'b0, pid_run)
    // Loss gone, a software clear drops the loss flag and the stop bit
    tgt[1] <= 14'h0000;
    wr(REG_STAT, 32'h0000_0001);
    rd(REG_STAT, '0, 32'h0000_0003);
    wr(REG_CTRL, ctl(1, 2, 1, 0, 0));
    poll(REG_STAT, 32'h0000_0003, '0, 1'b0);
    rd(REG_STAT, '0, 32'h0000_0003);
    $display("test loss done");
    // Sleep on low output, wake once demand returns
    tgt[1] <= 14'h0000;
    wr(REG_LIM, '0);
    wr(REG_LVL, 32'h0000_FDE8);
    wr(REG_CTRL, ctl(4, 1, 1, 0, 0));
    poll(REG_STAT, 32'h0000_0004, 32'h0000_0004, 1'b0);
    rd(REG_OUT, '0, 32'h0000_FFFF);
    wr(REG_LVL, '0);
    wr(REG_KEY, 32'h0000_03E8);
    poll(REG_STAT, 32'h0000_0004, '0, 1'b0);
    poll(REG_OUT, 32'h0000_FFFF, '0, 1'b1);
    rdnz(REG_OUT, 32'h0000_FFFF);
    $display("test sleep done");
    // Equal display bounds pin the shown value whatever the feedback
    wr(REG_DISP, (32'd50 << DISP_MAX_LSB) | (32'd50 << DISP_MIN_LSB));
    slow <= 1'b1;
    repeat (4) begin
      tgt[1] <= 14'($random(seed)) & 14'h1FFF;
      repeat (10 * TK) @(posedge clk_sys);
      rd(REG_OUT, 32'd50 << 16, 32'h03FF_0000);
      `CHK("display pin", 10'h032, fb_display)
    end
    $display("test display done");
    summarize();
  end
endmodule // pidfc_tb_top
`default_nettype wire

/* hdl/pidfc_persist.sv */
`timescale 1ns/1ns
`default_nettype none
// Counts ticks while a condition holds; done once the limit is reached
module pidfc_persist #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             tick,
  input  wire logic             cond,
  input  wire logic [CNT_W-1:0] limit,
  output logic                  done
);
  logic [CNT_W-1:0] cnt_reg;

  // Condition dropping restarts the wait at once
  always_ff @(posedge clk_sys) begin
    if (!rstn || !cond) begin
      cnt_reg <= '0;
    end else if (tick && cnt_reg < limit) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign done = cond && (cnt_reg >= limit);
endmodule // pidfc_persist
`default_nettype wire

/* hdl/pidfc_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Function
// - Setpoint from five sources, codes 0-4
// - Setpoint choice latched only when source is 6
// - Feedback from four sources, codes 0-3
// - Op 0 off; 1,3 deviation-D; 2,4 feedback-D
// - Codes 3,4 invert the control direction
// - Deviation is setpoint minus gained feedback
// - Proportional gain 0.0 to 10.0
// - Integral time 0.0 to 100.0 s
// - Derivative time 0.00 to 10.00 s
// - Output offset 0-109 %, signed by polarity
// - Output lag filter 0.0 to 2.5 s
// - Loss mode: off, indicate, or indicate and stop
// - Loss when deviation exceeds loss level
// - Loss declared after programmable persist delay
// - Integrator clamped to programmable limit
// - Settled error zeroes integrator and stops drive
// - Restart tolerance in 1/8192 units
// - Low output for sleep delay enters sleep
// - Output above wake level leaves sleep
// - Feedback display scaling only, not control
module pidfc_top
  import pidfc_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF,
  parameter int FMAX_CHZ = FMAX_CHZ_DEF
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic [7:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic [31:0]           avs_readdata,
  output logic                  avs_waitrequest,
  input  wire logic [SIG_W-1:0] keypad_pot,
  input  wire logic [SIG_W-1:0] voltage_analog_input,
  input  wire logic [SIG_W-1:0] current_analog_input,
  input  wire logic [SIG_W-1:0] comm_target,
  input  wire logic [SIG_W-1:0] comm_freq,
  output logic [15:0]           freq_ref,
  output logic                  pid_run,
  output logic                  feedback_loss_indication,
  output logic                  drive_stop,
  output logic [9:0]            fb_display
);
  logic               ack_reg;
  logic [31:0]        rdata_reg;
  logic [31:0]        cfg_reg [N_CFG];
  logic [31:0]        div_reg;
  logic [2:0]         sp_sel_reg;
  logic signed [31:0] dprev_reg;
  logic signed [31:0] i_acc_reg;
  logic signed [31:0] y_reg;
  logic [15:0]        freq_ref_reg;
  logic               pid_run_reg;
  logic               loss_flag_reg;
  logic [9:0]         fb_disp_reg;
  pidfc_state_t       state_reg;
  pidfc_state_t       state_next;
  pidfc_stat_t        stat;
  logic               loss_done;
  logic               sleep_done;
  logic               wake_done;
  logic               ires_done;

  // Bus decode; every access waits exactly one cycle
  wire       req      = avs_read | avs_write;
  wire       acc_done = req & ack_reg;
  wire       cfg_hit  = (avs_address[7:5] == 3'h0);
  wire [2:0] cfg_idx  = avs_address[4:2];
  wire       wr_cfg   = avs_write & acc_done & cfg_hit;
  wire       wr_stat  = avs_write & acc_done & avs_byteenable[0] &
                        (avs_address[7:2] == REG_STAT[7:2]);
  wire       loss_clr = wr_stat & avs_writedata[STAT_LOSS_BIT];
  assign avs_waitrequest = req & ~ack_reg;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = be[b] ? new_v[8*b +: 8] : old_v[8*b +: 8];
    end
  endfunction

  // Configuration words, byte-lane writes
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
      for (int i = 0; i < N_CFG; i++) begin
        cfg_reg[i] <= CFG_RST[i];
      end
    end else begin
      ack_reg <= req & ~ack_reg;
      if (wr_cfg) begin
        cfg_reg[cfg_idx] <= merge(cfg_reg[cfg_idx], avs_writedata,
                                  avs_byteenable);
      end
    end
  end

  // Read data captured in the wait cycle, valid when wait drops
  wire [31:0] rd_mux =
    cfg_hit ? cfg_reg[cfg_idx] :
    (avs_address[7:2] == REG_STAT[7:2]) ? {27'h0, stat} :
    (avs_address[7:2] == REG_OUT[7:2]) ? {6'h0, fb_disp_reg, freq_ref_reg} :
    32'h0;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdata_reg <= 32'h0;
    end else if (avs_read && !ack_reg) begin
      rdata_reg <= rd_mux;
    end
  end
  assign avs_readdata = rdata_reg;

  // Field views
  wire [31:0] w_ctrl   = cfg_reg[REG_CTRL[4:2]];
  wire [31:0] w_gain   = cfg_reg[REG_GAIN[4:2]];
  wire [31:0] w_time   = cfg_reg[REG_TIME[4:2]];
  wire [31:0] w_lim    = cfg_reg[REG_LIM[4:2]];
  wire [31:0] w_dly    = cfg_reg[REG_DLY[4:2]];
  wire [31:0] w_lvl    = cfg_reg[REG_LVL[4:2]];
  wire [31:0] w_key    = cfg_reg[REG_KEY[4:2]];
  wire [31:0] w_disp   = cfg_reg[REG_DISP[4:2]];
  wire [2:0]  sp_sel   = w_ctrl[CTRL_SP_LSB +: 3];
  wire [1:0]  fb_sel   = w_ctrl[CTRL_FB_LSB +: 2];
  wire [2:0]  op       = w_ctrl[CTRL_OP_LSB +: 3];
  wire [3:0]  fsrc     = w_ctrl[CTRL_FSRC_LSB +: 4];
  wire        ofs_neg  = w_ctrl[CTRL_OPOL_BIT];
  wire [1:0]  lmode    = w_ctrl[CTRL_LMODE_LSB +: 2];
  wire [4:0]  lag      = w_time[TIME_LAG_LSB +: 5];
  wire [9:0]  ti       = w_time[TIME_TI_LSB +: 10];
  wire [4:0]  ires     = w_lim[LIM_IRES_LSB +: 5];
  wire [15:0] sleep_lv = w_lvl[LVL_SLEEP_LSB +: 16];
  wire [15:0] wake_lv  = w_lvl[LVL_WAKE_LSB +: 16];
  wire signed [31:0] fbg_k  = 32'(w_gain[GAIN_FBG_LSB +: 10]);
  wire signed [31:0] kp_k   = 32'(w_gain[GAIN_KP_LSB +: 10]);
  wire signed [31:0] td_k   = 32'(w_time[TIME_TD_LSB +: 10]);
  wire signed [31:0] ti_n   = 32'(ti) * 32'(TICKS_PER_DSEC);
  wire signed [31:0] lag_n  = 32'(lag) * 32'(TICKS_PER_DSEC);
  wire signed [31:0] ofs_k  = 32'(w_lim[LIM_OFS_LSB +: 7]);
  wire signed [31:0] ilim_k = 32'(w_lim[LIM_INT_LSB +: 7]);
  wire signed [31:0] loss_k = 32'(w_lim[LIM_LOSS_LSB +: 7]);
  wire signed [31:0] key_k  = 32'(w_key[KEY_SP_LSB +: 10]);
  wire signed [31:0] marg_k = 32'(w_key[KEY_MARGIN_LSB +: 14]);
  wire signed [31:0] dmax_k = 32'(w_disp[DISP_MAX_LSB +: 10]);
  wire signed [31:0] dmin_k = 32'(w_disp[DISP_MIN_LSB +: 10]);

  // Control tick divider
  wire tick = (div_reg == 32'(TICK_CYC - 1));
  always_ff @(posedge clk_sys) begin
    if (!rstn || tick) begin
      div_reg <= 32'h0;
    end else begin
      div_reg <= div_reg + 32'h1;
    end
  end

  // Controller runs only as the drive's frequency source
  wire active = (op != OP_OFF) && (fsrc == FSRC_PID);

  // Setpoint choice held while another frequency source rules
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sp_sel_reg <= SP_KEYPOT;
    end else if (fsrc == FSRC_PID) begin
      sp_sel_reg <= sp_sel;
    end
  end

  // Setpoint and feedback selection
  wire signed [31:0] sp =
    (sp_sel_reg == SP_KEYPOT) ? 32'(keypad_pot) :
    (sp_sel_reg == SP_VOLT)   ? 32'(voltage_analog_input) :
    (sp_sel_reg == SP_CURR)   ? 32'(current_analog_input) :
    (sp_sel_reg == SP_COMM)   ? 32'(comm_target) :
    (sp_sel_reg == SP_STORED) ? key_k * FULL_SCALE / KEY_DIV : 32'sh0;
  wire signed [31:0] fb =
    (fb_sel == FB_KEYPOT) ? 32'(keypad_pot) :
    (fb_sel == FB_VOLT)   ? 32'(voltage_analog_input) :
    (fb_sel == FB_CURR)   ? 32'(current_analog_input) :
    32'(comm_freq);

  // Deviation and direction
  wire signed [31:0] fbg = fb * fbg_k / GAIN_DIV;
  wire signed [31:0] dev = sp - fbg;
  wire reverse_acting  = (op == OP_REV_DEV) || (op == OP_REV_FB);
  wire d_fb = (op == OP_FWD_FB) || (op == OP_REV_FB);
  wire signed [31:0] err  = reverse_acting ? -dev : dev;
  wire signed [31:0] dsrc = d_fb ? (reverse_acting ? fbg : -fbg) : err;

  // P, I and D terms; integrator keeps 8 fraction bits
  wire signed [31:0] p_t    = err * kp_k / KP_DIV;
  wire signed [31:0] d_t    = (dsrc - dprev_reg) * td_k;
  wire signed [31:0] i_step =
    (ti_n == 0) ? 32'sh0 : (err <<< FRAC_SH) / ti_n;
  wire signed [31:0] i_lim  =
    (ilim_k * FULL_SCALE / PCT_DIV) <<< FRAC_SH;
  wire signed [31:0] i_sum  = tick ? i_acc_reg + i_step : i_acc_reg;
  wire signed [31:0] i_clmp =
    (i_sum > i_lim) ? i_lim : (i_sum < -i_lim) ? -i_lim : i_sum;

  // Sum, offset and output clamp
  wire signed [31:0] u   = p_t + (i_acc_reg >>> FRAC_SH) + d_t;
  wire signed [31:0] ofs = ofs_k * FULL_SCALE / PCT_DIV;
  wire signed [31:0] u2  = ofs_neg ? u - ofs : u + ofs;
  wire signed [31:0] pct =
    (u2 < 0) ? 32'sh0 : (u2 > FULL_SCALE) ? 32'(FULL_SCALE) : u2;

  // Lag filter steps a 1/N share of the gap per tick
  wire signed [31:0] y_tgt  = pct <<< FRAC_SH;
  wire signed [31:0] y_next =
    (lag_n == 0) ? y_tgt : y_reg + (y_tgt - y_reg) / lag_n;
  wire [15:0] freq_calc =
    16'((y_reg >>> FRAC_SH) * FMAX_CHZ / FULL_SCALE);

  // Loss, settle and sleep conditions
  wire loss_cond = active && (lmode != LM_OFF) &&
                   (dev > loss_k * FULL_SCALE / PCT_DIV);
  wire signed [31:0] abs_dev = (dev < 0) ? -dev : dev;
  wire settled    = abs_dev <= marg_k;
  wire ires_cond  = active && (state_reg == ST_RUN) &&
                    (ires != 5'h0) && settled;
  wire sleep_cond = active && (state_reg == ST_RUN) &&
                    (freq_calc < sleep_lv);
  wire wake_cond  = active && (state_reg == ST_SLEEP) &&
                    (freq_calc > wake_lv);
  wire [15:0] loss_lim  = 16'(w_dly[DLY_LOSS_LSB +: 8]) * TICKS_PER_DSEC;
  wire [15:0] sleep_lim = 16'(w_dly[DLY_SLEEP_LSB +: 8]) * TICKS_PER_DSEC;
  wire [15:0] wake_lim  = 16'(w_dly[DLY_WAKE_LSB +: 8]) * TICKS_PER_DSEC;
  wire [15:0] ires_lim  = 16'(ires) * TICKS_PER_SEC;

  // Four persistence timers share one counter design
  pidfc_persist #(.CNT_W(16)) u_loss_tmr (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .tick    (tick),
    .cond    (loss_cond),
    .limit   (loss_lim),
    .done    (loss_done)
  );
  pidfc_persist #(.CNT_W(16)) u_sleep_tmr (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .tick    (tick),
    .cond    (sleep_cond),
    .limit   (sleep_lim),
    .done    (sleep_done)
  );
  pidfc_persist #(.CNT_W(16)) u_wake_tmr (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .tick    (tick),
    .cond    (wake_cond),
    .limit   (wake_lim),
    .done    (wake_done)
  );
  pidfc_persist #(.CNT_W(16)) u_ires_tmr (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .tick    (tick),
    .cond    (ires_cond),
    .limit   (ires_lim),
    .done    (ires_done)
  );

  // Run, integrator hold and sleep sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (ires_done) begin
          state_next = ST_IHOLD;
        end else if (sleep_done) begin
          state_next = ST_SLEEP;
        end
      end
      ST_IHOLD: begin
        if (!settled) begin
          state_next = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (wake_done) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_RUN;
    endcase
    if (!active) begin
      state_next = ST_RUN;
    end
  end

  // Loss flag: a new loss beats a software clear in the same cycle
  wire loss_flag_next = (lmode != LM_OFF) &&
                        (loss_done || (loss_flag_reg && !loss_clr));
  assign drive_stop = loss_flag_reg && (lmode == LM_STOP);
  wire hold_i  = !active || (state_next == ST_IHOLD) ||
                 (state_reg == ST_IHOLD);
  wire run_now = active && (state_next == ST_RUN) && !drive_stop;

  // Display scaling never feeds the loop
  wire signed [31:0] disp_v = dmin_k + fb * (dmax_k - dmin_k) / FULL_SCALE;

  // Loop state and outputs
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_reg     <= ST_RUN;
      i_acc_reg     <= 32'sh0;
      y_reg         <= 32'sh0;
      dprev_reg     <= 32'sh0;
      freq_ref_reg  <= 16'h0000;
      pid_run_reg   <= 1'b0;
      loss_flag_reg <= 1'b0;
      fb_disp_reg   <= 10'h000;
    end else begin
      state_reg     <= state_next;
      i_acc_reg     <= hold_i ? 32'sh0 : i_clmp;
      loss_flag_reg <= loss_flag_next;
      pid_run_reg   <= run_now;
      freq_ref_reg  <= run_now ? freq_calc : 16'h0000;
      fb_disp_reg   <= 10'(disp_v);
      if (!active) begin
        y_reg     <= 32'sh0;
        dprev_reg <= 32'sh0;
      end else if (tick) begin
        y_reg     <= y_next;
        dprev_reg <= dsrc;
      end
    end
  end

  assign stat = '{active: active, ihold: (state_reg == ST_IHOLD),
                  sleeping: (state_reg == ST_SLEEP), stop: drive_stop,
                  loss: loss_flag_reg};
  assign freq_ref = freq_ref_reg;
  assign pid_run = pid_run_reg;
  assign feedback_loss_indication = loss_flag_reg;
  assign fb_display = fb_disp_reg;

  // Checks on the loop's outputs, state, integrator and bus handshake
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_sleep_entry;
    (state_reg == ST_RUN) ##1 (state_reg == ST_SLEEP);
  endsequence
  sequence s_bus_req;
    req && !ack_reg;
  endsequence

  property p_fsrc_other;
    (fsrc != FSRC_PID) |=> (!pid_run_reg && freq_ref_reg == 16'h0000);
  endproperty
  a_fsrc_other: assert property (p_fsrc_other)
    else $error("controller ran while not frequency source");
  property p_op_off;
    (op == OP_OFF) |=> (freq_ref_reg == 16'h0000);
  endproperty
  a_op_off: assert property (p_op_off)
    else $error("output nonzero with controller disabled");
  property p_lm_off;
    (lmode == LM_OFF) |=> !loss_flag_reg;
  endproperty
  a_lm_off: assert property (p_lm_off)
    else $error("loss shown with detection disabled");
  property p_loss_stop;
    drive_stop |=> !pid_run_reg;
  endproperty
  a_loss_stop: assert property (p_loss_stop)
    else $error("drive kept running after loss stop");
  property p_loss_dly;
    $rose(loss_flag_reg) |-> $past(loss_done);
  endproperty
  a_loss_dly: assert property (p_loss_dly)
    else $error("loss declared before delay elapsed");
  property p_int_lim;
    $stable(i_lim) |-> (i_acc_reg <= i_lim) && (i_acc_reg >= -i_lim);
  endproperty
  a_int_lim: assert property (p_int_lim)
    else $error("integrator beyond limit");
  property p_ihold;
    (state_reg == ST_IHOLD) |-> (i_acc_reg == 32'sh0 && !pid_run_reg);
  endproperty
  a_ihold: assert property (p_ihold)
    else $error("integrator not zero in hold");
  property p_sleep;
    s_sleep_entry |-> (freq_ref_reg == 16'h0000 && !pid_run_reg);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("output not zero on sleep entry");
  property p_wake;
    (state_reg == ST_SLEEP && active && !wake_done) |=>
      (state_reg == ST_SLEEP);
  endproperty
  a_wake: assert property (p_wake)
    else $error("woke before wake delay");
  property p_out_max;
    freq_ref_reg <= 16'(FMAX_CHZ);
  endproperty
  a_out_max: assert property (p_out_max)
    else $error("frequency command above maximum");
  property p_bus;
    s_bus_req |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus answer not in second cycle");
endmodule // pidfc_top
`default_nettype wire

/* shared/pidfc_pkg.sv */
`default_nettype none
package pidfc_pkg;
  // Time base: one control tick every 10 ms
  localparam int CLK_PERIOD_NS  = 50;
  localparam int TICK_PERIOD_NS = 10_000_000;
  localparam int TICK_CYC_DEF   =
    (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] TICKS_PER_DSEC = 16'h000A;
  localparam logic [15:0] TICKS_PER_SEC  = 16'h0064;

  // Scaling: signals are 14-bit, 8192 is full scale
  localparam int SIG_W        = 14;
  localparam int FULL_SCALE   = 8192;
  localparam int PCT_DIV      = 100;
  localparam int KEY_DIV      = 1000;
  localparam int GAIN_DIV     = 100;
  localparam int KP_DIV       = 10;
  localparam int FRAC_SH      = 8;
  localparam int FMAX_CHZ_DEF = 6000;

  // Register byte offsets
  localparam int N_CFG = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_GAIN = 8'h04;
  localparam logic [7:0] REG_TIME = 8'h08;
  localparam logic [7:0] REG_LIM  = 8'h0C;
  localparam logic [7:0] REG_DLY  = 8'h10;
  localparam logic [7:0] REG_LVL  = 8'h14;
  localparam logic [7:0] REG_KEY  = 8'h18;
  localparam logic [7:0] REG_DISP = 8'h1C;
  localparam logic [7:0] REG_STAT = 8'h20;
  localparam logic [7:0] REG_OUT  = 8'h24;

  // Field positions
  localparam int CTRL_SP_LSB = 0;
  localparam int CTRL_FB_LSB = 3;
  localparam int CTRL_OP_LSB = 5;
  localparam int CTRL_FSRC_LSB = 8;
  localparam int CTRL_OPOL_BIT = 12;
  localparam int CTRL_LMODE_LSB = 13;
  localparam int GAIN_FBG_LSB = 0;
  localparam int GAIN_KP_LSB = 16;
  localparam int TIME_TI_LSB = 0;
  localparam int TIME_TD_LSB = 10;
  localparam int TIME_LAG_LSB = 20;
  localparam int LIM_OFS_LSB = 0;
  localparam int LIM_INT_LSB = 8;
  localparam int LIM_LOSS_LSB = 16;
  localparam int LIM_IRES_LSB = 24;
  localparam int DLY_LOSS_LSB = 0;
  localparam int DLY_SLEEP_LSB = 8;
  localparam int DLY_WAKE_LSB = 16;
  localparam int LVL_SLEEP_LSB = 0;
  localparam int LVL_WAKE_LSB = 16;
  localparam int KEY_SP_LSB = 0;
  localparam int KEY_MARGIN_LSB = 16;
  localparam int DISP_MAX_LSB = 0;
  localparam int DISP_MIN_LSB = 16;
  localparam int STAT_LOSS_BIT = 0;

  // Reset values, in offset order
  localparam logic [31:0] CFG_RST [N_CFG] = '{
    32'h0000_0000, 32'h000A_0064, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_03E7};

  // Codes
  localparam logic [3:0] FSRC_PID = 4'h6;
  localparam logic [2:0] SP_KEYPOT = 3'h0;
  localparam logic [2:0] SP_VOLT = 3'h1;
  localparam logic [2:0] SP_CURR = 3'h2;
  localparam logic [2:0] SP_COMM = 3'h3;
  localparam logic [2:0] SP_STORED = 3'h4;
  localparam logic [1:0] FB_KEYPOT = 2'h0;
  localparam logic [1:0] FB_VOLT = 2'h1;
  localparam logic [1:0] FB_CURR = 2'h2;
  localparam logic [2:0] OP_OFF = 3'h0;
  localparam logic [2:0] OP_FWD_FB = 3'h2;
  localparam logic [2:0] OP_REV_DEV = 3'h3;
  localparam logic [2:0] OP_REV_FB = 3'h4;
  localparam logic [1:0] LM_OFF = 2'h0;
  localparam logic [1:0] LM_STOP = 2'h2;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_IHOLD = 2'b01,
    ST_SLEEP = 2'b10
  } pidfc_state_t;

  typedef struct packed {
    logic active;
    logic ihold;
    logic sleeping;
    logic stop;
    logic loss;
  } pidfc_stat_t;
endpackage
`default_nettype wire
